//--- hdl/dcr_defs.vh
// Register map, field positions, reset values and timing of the descriptor DMA control block
`ifndef DCR_DEFS_VH
`define DCR_DEFS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define DCR_OFF_BUS_MODE   8'h00
`define DCR_OFF_TX_POLL    8'h08
`define DCR_OFF_RX_POLL    8'h10
`define DCR_OFF_RX_BASE    8'h18
`define DCR_OFF_TX_BASE    8'h20
`define DCR_OFF_PROC_CTRL  8'h30
`define DCR_OFF_PROC_STAT  8'h34

// ************************************************************
// Bus mode control fields
// ************************************************************
`define DCR_BM_SOFT_RESET  0
`define DCR_BM_TX_PRIO     1
`define DCR_BM_GAP_LSB     2
`define DCR_BM_GAP_MSB     6
`define DCR_BM_BYTE_ORDER  7

// ************************************************************
// Process control and status fields
// ************************************************************
`define DCR_PC_TX_RUN      0
`define DCR_PC_RX_RUN      1
`define DCR_PS_TX_LSB      0
`define DCR_PS_RX_LSB      2
`define DCR_PS_SRST        4

// ************************************************************
// Reset values
// ************************************************************
`define DCR_RST_BUS_MODE   8'h00
`define DCR_RST_BASE       30'h00000000
`define DCR_RST_PROC_CTRL  2'h0

// ************************************************************
// Timing
// ************************************************************
`define DCR_CLK_PERIOD_NS  40
`define DCR_SRST_TIME_NS   400
`define DCR_DESC_DWORDS    4

`endif

//--- hdl/dcr_fifo.v
// Synchronous valid/ready FIFO built from flip-flops
`timescale 1ns/1ps
`default_nettype none

module dcr_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clear,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Honest full and empty from the fill count
  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];

  // Pointer and count update
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Storage write, no reset needed on data
  always @(posedge pclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

//--- hdl/dcr_arb.v
// Two-way descriptor fetch arbiter between transmit and receive
`timescale 1ns/1ps
`default_nettype none

module dcr_arb (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clear,
  input  wire       tx_prio,
  input  wire [1:0] req,
  input  wire       done,
  output wire [1:0] grant
);

  reg [1:0] grant_q;

  assign grant = grant_q;

  // One grant held until the memory answers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q <= 2'h0;
    end else if (clear || done) begin
      grant_q <= 2'h0;
    end else if (grant_q == 2'h0) begin
      if (req == 2'h3) begin
        grant_q <= tx_prio ? 2'h1 : 2'h2; // [R3]
      end else begin
        grant_q <= req;
      end
    end
  end

endmodule

`default_nettype wire

//--- hdl/dcr_dma_regs.v
// APB control registers and descriptor fetch engine of the bus-master DMA
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defs.vh"

// Functional notes
// R1: Byte order bit 0 gives little endian data, 1 big endian data only.
// R2: Successive descriptors are spaced by the programmed gap in dwords.
// R3: Competing requests: receive wins when arbitration bit 0, transmit when 1.
// R4: Writing 1 to soft reset resets internal logic, not configuration registers.
// R5: Soft reset bit clears itself when the internal reset sequence ends.
// R6: Software stops transmit and receive before setting soft reset.
// R7: Transmit poll write while suspended starts a descriptor fetch checking ownership.
// R8: Transmission resumes only if fetched descriptor is owned; else stays suspended.
// R9: Receive poll write while suspended fetches; ownership starts FIFO to buffer moves.
// R10: Software issues receive poll only while receive is suspended.
// R11: Transmit list base is writable, its two low bits read zero.
// R12: Receive list base at 18h is writable, two low bits read zero.
// R13: Software writes receive list base only while receive is stopped.
// R14: Transmit list base register sits at offset 20h.
// R15: Poll writes while running or stopped have no effect.
module dcr_dma_regs #(
  parameter DATA_W     = 32,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  output wire              mem_req,
  output wire [31:0]       mem_addr,
  output wire              mem_is_rx,
  input  wire              mem_ack,
  input  wire              mem_own,
  input  wire              tx_desc_done,
  input  wire              rx_desc_done,
  output wire              tx_active,
  output wire              rx_active,
  input  wire [DATA_W-1:0] tx_mem_data,
  output wire [DATA_W-1:0] tx_line_data,
  input  wire              rx_in_valid,
  output wire              rx_in_ready,
  input  wire [DATA_W-1:0] rx_in_data,
  output wire              dma_wr_valid,
  input  wire              dma_wr_ready,
  output wire [DATA_W-1:0] dma_wr_data,
  output wire              soft_reset_active
);

  // ************************************************************
  // Timing constants
  // ************************************************************
  localparam integer SRST_CYCLES_I =
    (`DCR_SRST_TIME_NS + `DCR_CLK_PERIOD_NS - 1) / `DCR_CLK_PERIOD_NS;
  localparam [7:0] SRST_CYCLES = SRST_CYCLES_I[7:0];
  localparam integer DESC_DW_I = `DCR_DESC_DWORDS;
  localparam [29:0] DESC_DW = DESC_DW_I[29:0];

  // Descriptor process states, also the status register codes
  localparam [1:0] ST_STOP  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  localparam [1:0] ST_SUSP  = 2'h3;

  // ************************************************************
  // Register state
  // ************************************************************
  reg  [7:0]  bus_mode_q;
  reg  [29:0] tx_base_q;
  reg  [29:0] rx_base_q;
  reg  [1:0]  run_q;
  reg  [7:0]  srst_cnt_q;
  reg         pready_q;
  reg         pslverr_q;
  reg  [31:0] prdata_q;
  reg  [31:0] rd_data;
  reg         rd_hit;

  wire [1:0]  grant;
  wire [1:0]  req;
  wire [1:0]  poll;
  wire [1:0]  done;
  wire [1:0]  ack;
  wire [3:0]  state_w;
  wire [59:0] addr_w;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [DATA_W-1:0] fifo_out_data;

  wire        srst_busy   = bus_mode_q[`DCR_BM_SOFT_RESET];
  wire        tx_prio     = bus_mode_q[`DCR_BM_TX_PRIO];
  wire        big_endian  = bus_mode_q[`DCR_BM_BYTE_ORDER];
  wire [29:0] gap_dw      = {25'h0, bus_mode_q[`DCR_BM_GAP_MSB:`DCR_BM_GAP_LSB]};
  wire [29:0] desc_step   = DESC_DW + gap_dw; // [R2]

  // ************************************************************
  // APB handshake: one wait cycle, then answer
  // ************************************************************
  wire access  = psel & penable;
  wire wr_fire = access & pwrite & pready_q;

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // Byte swap for big endian buffers
  function [DATA_W-1:0] swap_bytes;
    input [DATA_W-1:0] d;
    integer b;
    begin
      for (b = 0; b < DATA_W / 8; b = b + 1) begin
        swap_bytes[b*8 +: 8] = d[DATA_W-8-b*8 +: 8];
      end
    end
  endfunction

  // Read decode and unmapped detection
  always @* begin
    rd_data = 32'h0;
    rd_hit  = 1'b1;
    case (paddr)
      `DCR_OFF_BUS_MODE:  rd_data = {24'h0, bus_mode_q};
      `DCR_OFF_TX_POLL:   rd_data = 32'h0;
      `DCR_OFF_RX_POLL:   rd_data = 32'h0;
      `DCR_OFF_RX_BASE:   rd_data = {rx_base_q, 2'b00}; // [R12]
      `DCR_OFF_TX_BASE:   rd_data = {tx_base_q, 2'b00}; // [R11] [R14]
      `DCR_OFF_PROC_CTRL: rd_data = {30'h0, run_q};
      `DCR_OFF_PROC_STAT: rd_data = {27'h0, srst_busy, state_w};
      default:            rd_hit  = 1'b0;
    endcase
  end

  // Access phase answer registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (access && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~rd_hit;
      prdata_q  <= pwrite ? 32'h0 : rd_data;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ************************************************************
  // Configuration registers and soft reset sequence
  // ************************************************************
  wire wr_bus_mode = wr_fire & (paddr == `DCR_OFF_BUS_MODE);
  wire srst_set    = wr_bus_mode & pwdata[`DCR_BM_SOFT_RESET];

  // Bus mode; soft reset bit set by software, cleared by hardware
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_mode_q <= `DCR_RST_BUS_MODE;
      srst_cnt_q <= 8'h0;
    end else begin
      if (wr_bus_mode) begin
        bus_mode_q[7:1] <= pwdata[7:1];
      end
      if (srst_set) begin
        bus_mode_q[`DCR_BM_SOFT_RESET] <= 1'b1; // [R4]
        srst_cnt_q <= SRST_CYCLES;
      end else if (srst_busy) begin
        if (srst_cnt_q == 8'h1 || srst_cnt_q == 8'h0) begin
          bus_mode_q[`DCR_BM_SOFT_RESET] <= 1'b0; // [R5]
          srst_cnt_q <= 8'h0;
        end else begin
          srst_cnt_q <= srst_cnt_q - 8'h1;
        end
      end
    end
  end

  // List base registers, low two bits not stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_base_q <= `DCR_RST_BASE;
      rx_base_q <= `DCR_RST_BASE;
    end else begin
      if (wr_fire && paddr == `DCR_OFF_TX_BASE) begin
        tx_base_q <= pwdata[31:2]; // [R11] [R14]
      end
      if (wr_fire && paddr == `DCR_OFF_RX_BASE) begin
        rx_base_q <= pwdata[31:2]; // [R12] [R13]
      end
    end
  end

  // Process run bits, dropped by soft reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= `DCR_RST_PROC_CTRL;
    end else if (srst_busy) begin
      run_q <= 2'h0; // [R4] [R6]
    end else if (wr_fire && paddr == `DCR_OFF_PROC_CTRL) begin
      run_q <= pwdata[1:0];
    end
  end

  // Poll demand strobes, any written value counts
  assign poll[0] = wr_fire & (paddr == `DCR_OFF_TX_POLL); // [R7]
  assign poll[1] = wr_fire & (paddr == `DCR_OFF_RX_POLL); // [R9] [R10]
  assign done    = {rx_desc_done, tx_desc_done};
  assign ack     = grant & {2{mem_ack}};

  // ************************************************************
  // Transmit (0) and receive (1) descriptor processes
  // ************************************************************
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : chan
      reg  [1:0]  st_q;
      reg  [29:0] addr_q;
      wire [29:0] base = (c == 0) ? tx_base_q : rx_base_q;

      // Stop, fetch, run and suspend sequencing
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_q   <= ST_STOP;
          addr_q <= `DCR_RST_BASE;
        end else if (srst_busy || !run_q[c]) begin
          st_q   <= ST_STOP; // [R4]
        end else begin
          case (st_q)
            ST_STOP: begin
              addr_q <= base;
              st_q   <= ST_FETCH;
            end
            ST_FETCH: begin
              if (ack[c]) begin
                st_q <= mem_own ? ST_RUN : ST_SUSP; // [R8] [R9]
              end
            end
            ST_RUN: begin
              if (done[c]) begin
                addr_q <= addr_q + desc_step; // [R2]
                st_q   <= ST_FETCH;
              end
            end
            ST_SUSP: begin
              if (poll[c]) begin
                st_q <= ST_FETCH; // [R7] [R9] [R15]
              end
            end
            default: begin
              st_q <= ST_STOP;
            end
          endcase
        end
      end

      assign req[c]                 = (st_q == ST_FETCH);
      assign state_w[2*c+1:2*c]     = st_q;
      assign addr_w[30*c+29:30*c]   = addr_q;
    end
  endgenerate

  // ************************************************************
  // Descriptor fetch arbitration and memory request
  // ************************************************************
  dcr_arb u_arb (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (srst_busy),
    .tx_prio (tx_prio),
    .req     (req),
    .done    (mem_ack),
    .grant   (grant)
  );

  assign mem_req   = |grant;
  assign mem_is_rx = grant[1];
  assign mem_addr  = grant[1] ? {addr_w[59:30], 2'b00} : {addr_w[29:0], 2'b00};

  assign tx_active = (state_w[1:0] == ST_RUN); // [R8]
  assign rx_active = (state_w[3:2] == ST_RUN); // [R9]
  assign soft_reset_active = srst_busy;

  // ************************************************************
  // Data paths with byte order selection
  // ************************************************************
  assign tx_line_data = big_endian ? swap_bytes(tx_mem_data) : tx_mem_data; // [R1]

  dcr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (srst_busy),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // FIFO drains to the buffer only while receive owns a descriptor
  assign dma_wr_valid   = fifo_out_valid & rx_active; // [R9]
  assign fifo_out_ready = dma_wr_ready & rx_active;
  assign dma_wr_data    = big_endian ? swap_bytes(fifo_out_data) : fifo_out_data; // [R1]

endmodule

`default_nettype wire

//--- test/dcr_dma_checker.sv
// Port-level assertions on the descriptor DMA control block
`timescale 1ns/1ps
`default_nettype none

module dcr_dma_checker #(
  parameter DATA_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              mem_req,
  input wire logic [31:0]       mem_addr,
  input wire logic              mem_is_rx,
  input wire logic              mem_ack,
  input wire logic              mem_own,
  input wire logic              tx_active,
  input wire logic              rx_active,
  input wire logic [DATA_W-1:0] tx_mem_data,
  input wire logic [DATA_W-1:0] tx_line_data,
  input wire logic              soft_reset_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Sequences and checks
  // ****************************************
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence

  sequence s_srst_run;
    soft_reset_active [*8];
  endsequence

  AST_PREADY_WAIT: assert property (s_setup |=> pready)
    else $error("pready missing in second access cycle");
  AST_FETCH_HOLD: assert property (mem_req && !mem_ack && !soft_reset_active |=>
    mem_req && $stable(mem_addr) && $stable(mem_is_rx))
    else $error("fetch request dropped or changed before ack");
  AST_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("descriptor address not dword aligned");
  AST_TX_OWN: assert property (mem_req && mem_ack && !mem_is_rx && !soft_reset_active |=>
    tx_active == $past(mem_own))
    else $error("transmit run state does not follow ownership");
  AST_RX_OWN: assert property (mem_req && mem_ack && mem_is_rx && !soft_reset_active |=>
    rx_active == $past(mem_own))
    else $error("receive run state does not follow ownership");
  AST_SWAP: assert property (tx_line_data == tx_mem_data || tx_line_data ==
    {tx_mem_data[7:0], tx_mem_data[15:8], tx_mem_data[23:16], tx_mem_data[31:24]})
    else $error("transmit data neither straight nor byte swapped");
  AST_SRST_LEN: assert property ($rose(soft_reset_active) |-> s_srst_run ##[1:4] !soft_reset_active)
    else $error("soft reset bit length wrong");
  AST_SRST_STOP: assert property (soft_reset_active [*2] |-> !tx_active && !rx_active)
    else $error("process active during soft reset");
endmodule

bind dcr_dma_regs dcr_dma_checker #(.DATA_W(DATA_W)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_is_rx(mem_is_rx), .mem_ack(mem_ack),
  .mem_own(mem_own), .tx_active(tx_active), .rx_active(rx_active), .tx_mem_data(tx_mem_data),
  .tx_line_data(tx_line_data), .soft_reset_active(soft_reset_active)
);

`default_nettype wire

//--- test/dcr_mem_model.sv
// Behavioural system memory answering descriptor fetches
`timescale 1ns/1ps
`default_nettype none

module dcr_mem_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic mem_req,
  input  wire logic own_i,
  input  wire logic stall_i,
  input  wire logic slow_i,
  output var  logic mem_ack,
  output var  logic mem_own
);
  logic [1:0] wait_q;

  // Ack after zero or three waits; ownership moves when not answering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_own <= 1'b0;
      wait_q  <= 2'h0;
    end else if (mem_req && !mem_ack && !stall_i && (!slow_i || wait_q == 2'h3)) begin
      mem_ack <= 1'b1;
      mem_own <= own_i;
      wait_q  <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_own <= ~mem_own;
      if (mem_req && !mem_ack && wait_q != 2'h3) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

//--- test/tb.sv
// Self-checking testbench of the descriptor DMA control registers
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defs.vh"

module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, tx_mem_data = 32'h11223344, rx_in_data = 32'h0;
  logic        own = 1'b0, stall = 1'b0, slow = 1'b0, rerr, tx_desc_done = 1'b0;
  logic        rx_in_valid = 1'b0, dma_wr_ready = 1'b0, rx_desc_done = 1'b0;
  wire  [31:0] prdata, mem_addr, tx_line_data, dma_wr_data;
  wire         pready, pslverr, mem_req, mem_is_rx, mem_ack, mem_own, tx_active, rx_active;
  wire         rx_in_ready, dma_wr_valid, soft_reset_active;
  wire  [3:0]  watch = {dma_wr_valid, rx_active, tx_active, mem_req};
  int          errors = 0, comparisons = 0;

  always #20 pclk = ~pclk;

  dcr_dma_regs i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_is_rx(mem_is_rx), .mem_ack(mem_ack),
    .mem_own(mem_own), .tx_desc_done(tx_desc_done), .rx_desc_done(rx_desc_done), .tx_active(tx_active),
    .rx_active(rx_active), .tx_mem_data(tx_mem_data), .tx_line_data(tx_line_data),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data),
    .dma_wr_valid(dma_wr_valid), .dma_wr_ready(dma_wr_ready), .dma_wr_data(dma_wr_data),
    .soft_reset_active(soft_reset_active)
  );

  dcr_mem_model i_mem (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .own_i(own), .stall_i(stall),
    .slow_i(slow), .mem_ack(mem_ack), .mem_own(mem_own)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk(32'(n), 32'h0);
      give_verdict();
    end
  endtask

  // Bounded wait for one watched output
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (watch[sel] !== 1'b1 && n < 100);
    if (n >= 100) begin
      chk(32'(sel), 32'hff);
      give_verdict();
    end
  endtask

  // Push words until the buffer refuses
  task automatic fill(output int n);
    n = 0;
    @(posedge pclk);
    rx_in_valid <= 1'b1;
    rx_in_data  <= 32'h11223300;
    do begin
      @(posedge pclk);
      if (rx_in_ready === 1'b1) n++;
      rx_in_data <= 32'h11223300 + 32'(n);
    end while (rx_in_ready === 1'b1 && n < 20);
    rx_in_valid <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_regs();
    logic [7:0] offs [4] = '{`DCR_OFF_BUS_MODE, `DCR_OFF_RX_BASE, `DCR_OFF_TX_BASE, `DCR_OFF_PROC_CTRL};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rdat, 32'h0);
    end
    apb(1'b1, `DCR_OFF_RX_BASE, 32'hffffffff);
    apb(1'b0, `DCR_OFF_RX_BASE, 32'h0);
    chk(rdat, 32'hfffffffc);
    apb(1'b1, `DCR_OFF_TX_BASE, 32'habcdef03);
    apb(1'b0, `DCR_OFF_TX_BASE, 32'h0);
    chk(rdat, 32'habcdef00);
    apb(1'b1, 8'h3c, 32'h1);
    chk(32'(rerr), 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
  endtask

  task automatic s_tx();
    apb(1'b1, `DCR_OFF_TX_BASE, 32'h100);
    apb(1'b1, `DCR_OFF_BUS_MODE, 32'h08);
    @(posedge pclk);
    chk(tx_line_data, 32'h11223344);
    slow <= 1'b1;
    apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h1);
    wait_for(0);
    chk(mem_addr, 32'h100);
    chk(32'(mem_is_rx), 32'h0);
    repeat (10) @(posedge pclk);
    apb(1'b0, `DCR_OFF_PROC_STAT, 32'h0);
    chk(32'(rdat[1:0]), 32'h3);
    own <= 1'b1;
    apb(1'b1, `DCR_OFF_TX_POLL, 32'h5a5a5a5a);
    wait_for(0);
    chk(mem_addr, 32'h100);
    wait_for(1);
    tx_desc_done <= 1'b1;
    @(posedge pclk);
    tx_desc_done <= 1'b0;
    own <= 1'b0;
    wait_for(0);
    chk(mem_addr, 32'h118);
    repeat (10) @(posedge pclk);
    apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h0);
    apb(1'b1, `DCR_OFF_TX_POLL, 32'h0);
    repeat (5) @(posedge pclk);
    chk(32'(mem_req), 32'h0);
    apb(1'b0, `DCR_OFF_PROC_STAT, 32'h0);
    chk(32'(rdat[1:0]), 32'h0);
    slow <= 1'b0;
  endtask

  task automatic s_arb();
    apb(1'b1, `DCR_OFF_RX_BASE, 32'h200);
    for (int p = 0; p < 2; p++) begin
      stall <= 1'b1;
      apb(1'b1, `DCR_OFF_BUS_MODE, 32'(p * 2));
      apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h3);
      wait_for(0);
      chk(32'(mem_is_rx), 32'(p == 0));
      apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h0);
      stall <= 1'b0;
      repeat (10) @(posedge pclk);
    end
  endtask

  task automatic s_rx();
    int n;
    int k;
    apb(1'b1, `DCR_OFF_BUS_MODE, 32'h80);
    fill(n);
    chk(32'(n), 32'h10);
    chk(tx_line_data, 32'h44332211);
    chk(32'(dma_wr_valid), 32'h0);
    apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h2);
    repeat (10) @(posedge pclk);
    apb(1'b0, `DCR_OFF_PROC_STAT, 32'h0);
    chk(32'(rdat[3:2]), 32'h3);
    own <= 1'b1;
    apb(1'b1, `DCR_OFF_RX_POLL, 32'h0);
    wait_for(2);
    n = 0;
    k = 0;
    while (n < 16 && k < 100) begin
      @(posedge pclk);
      k++;
      if (dma_wr_valid === 1'b1 && dma_wr_ready === 1'b1) begin
        chk(dma_wr_data, {8'h00 + n[7:0], 24'h332211});
        n++;
      end
      dma_wr_ready <= ~dma_wr_ready;
    end
    @(posedge pclk);
    chk(32'(dma_wr_valid), 32'h0);
    rx_desc_done <= 1'b1;
    @(posedge pclk);
    rx_desc_done <= 1'b0;
    wait_for(0);
    chk(mem_addr, 32'h210);
    apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h0);
  endtask

  task automatic s_srst();
    int n;
    fill(n);
    apb(1'b1, `DCR_OFF_PROC_CTRL, 32'h0);
    apb(1'b1, `DCR_OFF_BUS_MODE, 32'h8b);
    @(posedge pclk);
    chk(32'(soft_reset_active), 32'h1);
    n = 0;
    do begin
      apb(1'b0, `DCR_OFF_BUS_MODE, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 10);
    chk(rdat, 32'h8a);
    chk(32'(rx_in_ready), 32'h1);
    apb(1'b0, `DCR_OFF_RX_BASE, 32'h0);
    chk(rdat, 32'h200);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_tx();
    s_arb();
    s_rx();
    s_srst();
    give_verdict();
  end
endmodule

`default_nettype wire
